// [core/fifo_flag_consts.vh]
`ifndef FIFO_FLAG_CONSTS_VH
`define FIFO_FLAG_CONSTS_VH

// ==========================================================
// storage geometry
`define FIFO_DEPTH      12'h400
`define FIFO_AW         10
`define FIFO_DW         36
`define FIFO_PTR_W      11
`define FIFO_CNT_W      12
`define FIFO_OFS_W      11

// ==========================================================
// mark guard: least distance between pointers, bytes and words
`define MARK_MIN_BYTES  12'h020
`define BYTES_PER_WORD  12'h004
`define MARK_MIN_WORDS  (`MARK_MIN_BYTES / `BYTES_PER_WORD)

// ==========================================================
// layout of the sampled pin vector
`define PIN_W           70
`define PIN_WCLK        0
`define PIN_RCLK        1
`define PIN_MRS_N       2
`define PIN_FTS         3
`define PIN_FALL_THROUGH_MODE        4
`define PIN_WEN_N       5
`define PIN_RCS_N       6
`define PIN_REN_N       7
`define PIN_OE_N        8
`define PIN_RT_N        9
`define PIN_MARK_N      10
`define PIN_OFS_ACC     11
`define PIN_DATA_LO     12
`define PIN_DATA_HI     47
`define PIN_AE_LO       48
`define PIN_AE_HI       58
`define PIN_AF_LO       59
`define PIN_AF_HI       69
`define PIN_RESET       70'h0

// ==========================================================
// reset values of the data and flag outputs
`define DATA_RESET      36'h0
`define FLAG_RESET_N    1'h1
`define EMPTY_RESET_N   1'h0

`endif

// [core/fifo_word_store.v]
`timescale 1ns/100ps
`default_nettype none
`include "fifo_flag_consts.vh"

module fifo_word_store
(
  input  wire                    CLK,
  input  wire                    RST_N,
  input  wire                    ce,
  input  wire                    we,
  input  wire [`FIFO_AW-1:0]     waddr,
  input  wire [`FIFO_DW-1:0]     wdata,
  input  wire [`FIFO_AW-1:0]     raddr,
  output reg  [`FIFO_DW-1:0]     rdata
);

  reg [`FIFO_DW-1:0] mem [0:(1<<`FIFO_AW)-1];

  // ==========================================================
  // write port, no reset on the array
  always @(posedge CLK)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // ==========================================================
  // registered read port
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdata <= `DATA_RESET;
    end
    else if (ce)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule // fifo_word_store

`default_nettype wire

// [core/dual_clock_fifo_read_flag_logic.v]
`timescale 1ns/100ps
`default_nettype none
`include "fifo_flag_consts.vh"

module dual_clock_fifo_read_flag_logic
(
  input  wire                    CLK,
  input  wire                    RST_N,
  input  wire                    CE,
  input  wire                    WCLK,
  input  wire                    RCLK,
  input  wire                    MASTER_RESET_N,
  input  wire                    FLAG_TIMING_SELECT,
  input  wire                    FALL_THROUGH_MODE,
  input  wire                    WRITE_EN_N,
  input  wire [`FIFO_DW-1:0]     DATA_IN,
  input  wire                    READ_CHIP_SELECT_N,
  input  wire                    READ_EN_N,
  input  wire                    OUTPUT_EN_N,
  input  wire                    RETRANSMIT_N,
  input  wire                    MARK_N,
  input  wire                    OFFSET_ACCESS,
  input  wire [`FIFO_OFS_W-1:0]  AE_OFFSET,
  input  wire [`FIFO_OFS_W-1:0]  AF_OFFSET,
  output reg  [`FIFO_DW-1:0]     DATA_OUT_BUS,
  output reg                     DATA_OUT_OE,
  output reg                     EMPTY_INDICATOR_N,
  output reg                     OUTPUT_READY_N,
  output reg                     FULL_INDICATOR_N,
  output reg                     INPUT_READY_N,
  output reg                     ALMOST_EMPTY_N,
  output reg                     ALMOST_FULL_N,
  output reg                     HALF_FULL_N,
  output reg                     ECHO_READ_STROBE_N
);

  // ==========================================================
  // pin sampling: three stages, a change counts once stages two and three agree
  wire [`PIN_W-1:0] pins = {AF_OFFSET, AE_OFFSET, DATA_IN, OFFSET_ACCESS, MARK_N, RETRANSMIT_N, OUTPUT_EN_N,
                            READ_EN_N, READ_CHIP_SELECT_N, WRITE_EN_N, FALL_THROUGH_MODE, FLAG_TIMING_SELECT,
                            MASTER_RESET_N, RCLK, WCLK};
  reg  [`PIN_W-1:0] s1;
  reg  [`PIN_W-1:0] s2;
  reg  [`PIN_W-1:0] s3;
  reg  [`PIN_W-1:0] filt;
  reg               wclk_d;
  reg               rclk_d;

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1     <= `PIN_RESET;
      s2     <= `PIN_RESET;
      s3     <= `PIN_RESET;
      filt   <= `PIN_RESET;
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end
    else if (CE)
    begin
      s1     <= pins;
      s2     <= s1;
      s3     <= s2;
      filt   <= (s2 & s3) | (filt & (s2 ^ s3));
      wclk_d <= filt[`PIN_WCLK];
      rclk_d <= filt[`PIN_RCLK];
    end
  end

  wire                   wclk_rise = CE & filt[`PIN_WCLK] & ~wclk_d;
  wire                   rclk_rise = CE & filt[`PIN_RCLK] & ~rclk_d;
  wire                   master_reset_n       = ~filt[`PIN_MRS_N];
  wire                   wen_n     = filt[`PIN_WEN_N];
  wire                   rcs_n     = filt[`PIN_RCS_N];
  wire                   rd_req    = ~filt[`PIN_RCS_N] & ~filt[`PIN_REN_N];
  wire                   rt_n      = filt[`PIN_RT_N];
  wire                   mark_n    = filt[`PIN_MARK_N];
  wire                   ofs_acc   = filt[`PIN_OFS_ACC];
  wire [`FIFO_DW-1:0]    wdata     = filt[`PIN_DATA_HI:`PIN_DATA_LO];
  wire [`FIFO_OFS_W-1:0] ae_ofs    = filt[`PIN_AE_HI:`PIN_AE_LO];
  wire [`FIFO_OFS_W-1:0] af_ofs    = filt[`PIN_AF_HI:`PIN_AF_LO];

  // ==========================================================
  // state
  reg                    fts_mode;
  reg                    fall_through_mode_mode;
  reg [`FIFO_PTR_W-1:0]  wptr;
  reg [`FIFO_PTR_W-1:0]  rptr;
  reg [`FIFO_PTR_W-1:0]  rptr_wv;
  reg [`FIFO_PTR_W-1:0]  wptr_rv;
  reg [`FIFO_PTR_W-1:0]  mark_ptr;
  reg                    marked;
  reg                    ovalid;
  reg                    rt_setup;
  reg                    ofs_idx;
  reg                    ofs_prev;
  wire [`FIFO_DW-1:0]    rdata;

  // ==========================================================
  // occupancy; the output register counts as a word in fall-through
  wire [`FIFO_CNT_W-1:0] depth_d = `FIFO_DEPTH + {11'h000, fall_through_mode_mode};
  wire [`FIFO_CNT_W-1:0] af_thr  = depth_d - {1'b0, af_ofs};
  wire [`FIFO_CNT_W-1:0] hf_thr  = {1'b0, depth_d[`FIFO_CNT_W-1:1]} + 12'h001;
  wire [`FIFO_PTR_W-1:0] base_w  = marked ? mark_ptr : rptr_wv;
  wire [`FIFO_PTR_W-1:0] mem_w   = wptr - base_w;
  wire                   mem_full = ({1'b0, mem_w} == `FIFO_DEPTH);
  wire                   do_write = wclk_rise & ~master_reset_n & ~wen_n & ~mem_full;
  wire [`FIFO_PTR_W-1:0] next_wptr = wptr + {10'h000, do_write};
  wire [`FIFO_CNT_W-1:0] tot_w   = {1'b0, next_wptr - base_w} + {11'h000, ovalid};
  wire [`FIFO_CNT_W-1:0] tot_live = {1'b0, wptr - rptr} + {11'h000, ovalid};
  wire [`FIFO_PTR_W-1:0] mem_r   = wptr_rv - rptr;
  wire                   mem_has = (mem_r != 11'h000) & ~rt_setup;

  // ==========================================================
  // read-side next state
  reg [`FIFO_PTR_W-1:0]  next_rptr;
  reg                    next_ovalid;
  reg                    load;
  reg                    rt_go;
  wire                   ofs_rd = ofs_acc & rd_req & ~ofs_prev;

  always @*
  begin
    next_rptr   = rptr;
    next_ovalid = ovalid;
    load        = 1'b0;
    rt_go       = ~rt_n & marked;
    if (rt_go)
    begin
      next_rptr   = mark_ptr;
      next_ovalid = 1'b0;
    end
    else if (ofs_acc)
    begin
      load = 1'b0;
    end
    else if (fall_through_mode_mode)
    begin
      // an early strobe reads the fallen-through word away on the next read edge, so it is shown for one read cycle only
      if (mem_has && (!ovalid || rd_req))
      begin
        load        = 1'b1;
        next_ovalid = 1'b1;
        next_rptr   = rptr + 11'h001;
      end
      else if (ovalid && rd_req)
      begin
        next_ovalid = 1'b0;
      end
    end
    else if (rd_req && mem_has)
    begin
      load      = 1'b1;
      next_rptr = rptr + 11'h001;
    end
  end

  wire [`FIFO_CNT_W-1:0] tot_r = {1'b0, wptr_rv - next_rptr} + {11'h000, next_ovalid};

  fifo_word_store store
  (
    .CLK   (CLK),
    .RST_N (RST_N),
    .ce    (CE),
    .we    (do_write),
    .waddr (wptr[`FIFO_AW-1:0]),
    .wdata (wdata),
    .raddr (rptr[`FIFO_AW-1:0]),
    .rdata (rdata)
  );

  // ==========================================================
  // write-clock domain behaviour, plus half full, which follows both pointers on every system clock
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fts_mode         <= 1'b0;
      fall_through_mode_mode        <= 1'b0;
      wptr             <= 11'h000;
      rptr_wv          <= 11'h000;
      FULL_INDICATOR_N <= `FLAG_RESET_N;
      INPUT_READY_N    <= 1'b0;
      HALF_FULL_N      <= `FLAG_RESET_N;
    end
    else if (CE)
    begin
      if (master_reset_n)
      begin
        fts_mode         <= filt[`PIN_FTS];
        fall_through_mode_mode        <= filt[`PIN_FALL_THROUGH_MODE];
        wptr             <= 11'h000;
        rptr_wv          <= 11'h000;
        FULL_INDICATOR_N <= `FLAG_RESET_N;
        INPUT_READY_N    <= 1'b0;
        HALF_FULL_N      <= `FLAG_RESET_N;
      end
      else
      begin
        HALF_FULL_N <= ~(tot_live >= hf_thr);
        if (wclk_rise)
        begin
          wptr    <= next_wptr;
          // the stale read view delays release by one write cycle
          rptr_wv <= rptr;
          FULL_INDICATOR_N <= ~(tot_w >= depth_d);
          INPUT_READY_N    <= (tot_w >= depth_d);
        end
      end
    end
  end

  // ==========================================================
  // read-clock domain behaviour
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rptr               <= 11'h000;
      wptr_rv            <= 11'h000;
      mark_ptr           <= 11'h000;
      marked             <= 1'b0;
      ovalid             <= 1'b0;
      rt_setup           <= 1'b0;
      ofs_idx            <= 1'b0;
      ofs_prev           <= 1'b0;
      DATA_OUT_BUS       <= `DATA_RESET;
      EMPTY_INDICATOR_N  <= `EMPTY_RESET_N;
      OUTPUT_READY_N     <= `FLAG_RESET_N;
      ECHO_READ_STROBE_N <= `FLAG_RESET_N;
    end
    else if (CE)
    begin
      if (master_reset_n)
      begin
        rptr               <= 11'h000;
        wptr_rv            <= 11'h000;
        marked             <= 1'b0;
        ovalid             <= 1'b0;
        rt_setup           <= 1'b0;
        ofs_idx            <= 1'b0;
        ofs_prev           <= 1'b0;
        EMPTY_INDICATOR_N  <= `EMPTY_RESET_N;
        OUTPUT_READY_N     <= `FLAG_RESET_N;
        ECHO_READ_STROBE_N <= `FLAG_RESET_N;
      end
      else if (rclk_rise)
      begin
        wptr_rv  <= wptr;
        rptr     <= next_rptr;
        ovalid   <= next_ovalid;
        ofs_prev <= ofs_acc & rd_req;
        rt_setup <= rt_go;
        if (!mark_n && !marked && ({1'b0, mem_r} >= `MARK_MIN_WORDS))
        begin
          mark_ptr <= rptr;
        end
        marked <= ~mark_n & (marked | ({1'b0, mem_r} >= `MARK_MIN_WORDS));
        if (ofs_rd)
        begin
          DATA_OUT_BUS <= ofs_idx ? {25'h0000000, af_ofs} : {25'h0000000, ae_ofs};
          ofs_idx      <= ~ofs_idx;
        end
        else if (load)
        begin
          DATA_OUT_BUS <= rdata;
        end
        // retransmit holds empty low on every read edge while it stays low, then it returns
        EMPTY_INDICATOR_N <= ~rt_go & ({1'b0, wptr_rv - next_rptr} != 12'h000);
        OUTPUT_READY_N    <= ~next_ovalid;
        if (fall_through_mode_mode)
        begin
          ECHO_READ_STROBE_N <= ~load;
        end
        else
        begin
          ECHO_READ_STROBE_N <= ~rd_req | ~mem_has;
        end
      end
    end
  end

  // ==========================================================
  // programmable flags, synchronous or asynchronous per captured select
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ALMOST_FULL_N  <= `FLAG_RESET_N;
      ALMOST_EMPTY_N <= 1'b0;
    end
    else if (CE)
    begin
      if (master_reset_n)
      begin
        ALMOST_FULL_N  <= `FLAG_RESET_N;
        ALMOST_EMPTY_N <= 1'b0;
      end
      else if (fts_mode)
      begin
        if (wclk_rise)
        begin
          ALMOST_FULL_N <= ~(tot_w >= af_thr);
        end
        if (rclk_rise)
        begin
          ALMOST_EMPTY_N <= ~(tot_r <= {1'b0, ae_ofs});
        end
      end
      else
      begin
        if (wclk_rise && (tot_w >= af_thr))
        begin
          ALMOST_FULL_N <= 1'b0;
        end
        else if (rclk_rise && (tot_live < af_thr))
        begin
          ALMOST_FULL_N <= 1'b1;
        end
        if (rclk_rise && (tot_r <= {1'b0, ae_ofs}))
        begin
          ALMOST_EMPTY_N <= 1'b0;
        end
        else if (wclk_rise && (tot_w > {1'b0, ae_ofs}))
        begin
          ALMOST_EMPTY_N <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // bus enable; during master reset only the output enable counts
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DATA_OUT_OE <= 1'b0;
    end
    else if (CE)
    begin
      DATA_OUT_OE <= ~filt[`PIN_OE_N] & (master_reset_n | ~rcs_n);
    end
  end

endmodule // dual_clock_fifo_read_flag_logic

`default_nettype wire

// [tb/fifo_flag_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fifo_flag_consts.vh"

// ==========================================================
// outputs other than half full, the bus enable and the asynchronous almost flags move only in the clock domain that owns them
module fifo_flag_asserts
(
  input wire logic                CLK,
  input wire logic                RST_N,
  input wire logic                WCLK,
  input wire logic                RCLK,
  input wire logic                MASTER_RESET_N,
  input wire logic                FLAG_TIMING_SELECT,
  input wire logic                READ_CHIP_SELECT_N,
  input wire logic                OUTPUT_EN_N,
  input wire logic [`FIFO_DW-1:0] DATA_OUT_BUS,
  input wire logic                DATA_OUT_OE,
  input wire logic                EMPTY_INDICATOR_N,
  input wire logic                OUTPUT_READY_N,
  input wire logic                FULL_INDICATOR_N,
  input wire logic                INPUT_READY_N,
  input wire logic                ALMOST_EMPTY_N,
  input wire logic                ALMOST_FULL_N,
  input wire logic                ECHO_READ_STROBE_N
);
  // sampler plus output register take five cycles at most; seven leaves margin
  localparam int LAG = 7;
  logic [3:0] r_age;
  logic [3:0] w_age;
  logic [3:0] m_age;
  logic       quiet;
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      r_age <= 4'h0;
      w_age <= 4'h0;
      m_age <= 4'h0;
    end
    else
    begin
      r_age <= $rose(RCLK) ? 4'h0 : r_age + {3'h0, r_age != 4'hF};
      w_age <= $rose(WCLK) ? 4'h0 : w_age + {3'h0, w_age != 4'hF};
      m_age <= !MASTER_RESET_N ? 4'h0 : m_age + {3'h0, m_age != 4'hF};
    end
  end
  // master reset rewrites every flag, so it is masked out until long settled
  assign quiet = (m_age == 4'hF);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence oe_off6;
    OUTPUT_EN_N [*6];
  endsequence
  sequence rcs_off6;
    (READ_CHIP_SELECT_N && quiet) [*6];
  endsequence
  echo_on_rclk_a: assert property (quiet && $changed(ECHO_READ_STROBE_N) |-> r_age <= LAG)
    else $error("echo strobe moved without a read clock edge");
  data_on_rclk_a: assert property (quiet && $changed(DATA_OUT_BUS) |-> r_age <= LAG)
    else $error("output word moved without a read clock edge");
  empty_on_rclk_a: assert property (quiet && ($changed(EMPTY_INDICATOR_N) || $changed(OUTPUT_READY_N))
    |-> r_age <= LAG)
    else $error("empty or output ready moved without a read clock edge");
  ae_sync_rclk_a: assert property (quiet && FLAG_TIMING_SELECT && $changed(ALMOST_EMPTY_N) |-> r_age <= LAG)
    else $error("synchronous almost empty moved off the read clock");
  af_sync_wclk_a: assert property (quiet && FLAG_TIMING_SELECT && $changed(ALMOST_FULL_N) |-> w_age <= LAG)
    else $error("synchronous almost full moved off the write clock");
  ready_on_wclk_a: assert property (quiet && ($changed(FULL_INDICATOR_N) || $changed(INPUT_READY_N))
    |-> w_age <= LAG)
    else $error("full or input ready moved off the write clock");
  oe_off_a: assert property (oe_off6 |=> !DATA_OUT_OE)
    else $error("bus driven with output enable high");
  select_off_a: assert property (rcs_off6 |=> !DATA_OUT_OE)
    else $error("bus driven with read select high");
endmodule // fifo_flag_asserts

bind dual_clock_fifo_read_flag_logic fifo_flag_asserts chk (.CLK(CLK), .RST_N(RST_N), .WCLK(WCLK), .RCLK(RCLK),
  .MASTER_RESET_N(MASTER_RESET_N), .FLAG_TIMING_SELECT(FLAG_TIMING_SELECT), .READ_CHIP_SELECT_N(READ_CHIP_SELECT_N),
  .OUTPUT_EN_N(OUTPUT_EN_N), .DATA_OUT_BUS(DATA_OUT_BUS), .DATA_OUT_OE(DATA_OUT_OE),
  .EMPTY_INDICATOR_N(EMPTY_INDICATOR_N), .OUTPUT_READY_N(OUTPUT_READY_N), .FULL_INDICATOR_N(FULL_INDICATOR_N),
  .INPUT_READY_N(INPUT_READY_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N), .ALMOST_FULL_N(ALMOST_FULL_N),
  .ECHO_READ_STROBE_N(ECHO_READ_STROBE_N));
`default_nettype wire

// [tb/fifo_far_side.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fifo_flag_consts.vh"

// ==========================================================
// external writer on its own clock, plus the free-running read clock
module fifo_far_side
(
  output var logic                WCLK,
  output var logic                RCLK,
  output var logic                WRITE_EN_N,
  output var logic [`FIFO_DW-1:0] DATA_IN
);
  logic [`FIFO_DW-1:0] q[$];
  task push(input logic [`FIFO_DW-1:0] w);
    q.push_back(w);
  endtask
  // offsets keep both clock edges off the system clock edge
  initial
  begin
    WCLK = 1'b0;
    #3;
    forever #48 WCLK = ~WCLK;
  end
  initial
  begin
    RCLK = 1'b0;
    #13;
    forever #40 RCLK = ~RCLK;
  end
  // idle data toggles so a stale word never looks valid
  initial
  begin
    WRITE_EN_N = 1'b1;
    DATA_IN = 36'h0;
    forever
    begin
      @(posedge WCLK);
      #2;
      WRITE_EN_N = (q.size() == 0);
      DATA_IN = (q.size() > 0) ? q.pop_front() : ~DATA_IN;
    end
  end
endmodule // fifo_far_side
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fifo_flag_consts.vh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

// ==========================================================
// bench top
module tb;
  logic                clk;
  logic                rst_n;
  logic                mrs_n;
  logic                fts;
  logic                fall_through_mode;
  logic                rcs_n;
  logic                ren_n;
  logic                oe_n;
  logic [10:0]         ae_ofs;
  logic                rt_n;
  logic                mark_n;
  logic                ofs_acc;
  wire                 wclk, rclk, wen_n, oe, empty_n, ordy_n, full_n, irdy_n, ae_n, af_n, hf_n, echo_n;
  wire [`FIFO_DW-1:0]  din;
  wire [`FIFO_DW-1:0]  dout;
  int                  bad_count;
  int                  checks_done;

  fifo_far_side far (.WCLK(wclk), .RCLK(rclk), .WRITE_EN_N(wen_n), .DATA_IN(din));
  // retransmit, mark and offset access are driven only by their own scenarios
  dual_clock_fifo_read_flag_logic dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .WCLK(wclk), .RCLK(rclk),
    .MASTER_RESET_N(mrs_n), .FLAG_TIMING_SELECT(fts), .FALL_THROUGH_MODE(fall_through_mode), .WRITE_EN_N(wen_n),
    .DATA_IN(din), .READ_CHIP_SELECT_N(rcs_n), .READ_EN_N(ren_n), .OUTPUT_EN_N(oe_n), .RETRANSMIT_N(rt_n),
    .MARK_N(mark_n), .OFFSET_ACCESS(ofs_acc), .AE_OFFSET(ae_ofs), .AF_OFFSET(11'h008), .DATA_OUT_BUS(dout),
    .DATA_OUT_OE(oe), .EMPTY_INDICATOR_N(empty_n), .OUTPUT_READY_N(ordy_n), .FULL_INDICATOR_N(full_n),
    .INPUT_READY_N(irdy_n), .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n), .HALF_FULL_N(hf_n),
    .ECHO_READ_STROBE_N(echo_n));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [`FIFO_DW-1:0] wd(input int i);
    return 36'h5A5A50000 + 36'(i);
  endfunction

  task print_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // controls change 7 clocks after a read clock rise, well before the next one
  task rstep;
    @(posedge rclk);
    repeat (7) @(posedge clk);
    #1;
  endtask

  task master_reset(input logic f_sel, input logic ft);
    mrs_n = 1'b0;
    fts = f_sel;
    fall_through_mode = ft;
    rcs_n = 1'b1;
    ren_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    mrs_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task drain;
    int i;
    for (i = 0; i < 20000 && far.q.size() > 0; i++) @(posedge clk);
    if (i == 20000)
    begin
      bad_count++;
      print_verdict();
    end
    // a last write needs a write edge plus two read edges to reach the read flags
    repeat (80) @(posedge clk);
    #1;
  endtask

  task std_flow(input logic f_sel);
    int i;
    master_reset(f_sel, 1'b0);
    for (i = 0; i < 3; i++) far.push(wd(i));
    drain();
    `CHK("empty flag", 1'b1, empty_n)
    `CHK("almost empty", 1'b1, ae_n)
    rcs_n = 1'b0;
    ren_n = 1'b0;
    for (i = 0; i < 3; i++)
    begin
      rstep();
      `CHK("read word", wd(i), dout)
      `CHK("echo on read", 1'b0, echo_n)
    end
    `CHK("empty after", 1'b0, empty_n)
    `CHK("bus driven", 1'b1, oe)
    rstep();
    `CHK("echo empty", 1'b1, echo_n)
    `CHK("word held", wd(2), dout)
    `CHK("almost empty set", 1'b0, ae_n)
    oe_n = 1'b1;
    rstep();
    `CHK("bus released", 1'b0, oe)
    oe_n = 1'b0;
  endtask

  task fall_through_mode_flow;
    int i;
    master_reset(1'b1, 1'b1);
    for (i = 0; i < 3; i++) far.push(wd(10 + i));
    drain();
    `CHK("first fell", 1'b0, ordy_n)
    `CHK("first word", wd(10), dout)
    `CHK("bus off", 1'b0, oe)
    rcs_n = 1'b0;
    rstep();
    `CHK("first kept", wd(10), dout)
    `CHK("bus on", 1'b1, oe)
    ren_n = 1'b0;
    rstep();
    `CHK("second word", wd(11), dout)
    `CHK("echo load", 1'b0, echo_n)
    ren_n = 1'b1;
    rstep();
    `CHK("echo idle", 1'b1, echo_n)
    ren_n = 1'b0;
    rstep();
    `CHK("third word", wd(12), dout)
    rstep();
    `CHK("ready gone", 1'b1, ordy_n)
    ren_n = 1'b1;
    rcs_n = 1'b1;
    for (i = 0; i < 1024; i++) far.push(wd(i));
    drain();
    `CHK("room at 1024", 1'b0, irdy_n)
    `CHK("almost full", 1'b0, af_n)
    `CHK("half full", 1'b0, hf_n)
    far.push(wd(1024));
    drain();
    `CHK("full at 1025", 1'b1, irdy_n)
    rcs_n = 1'b0;
    ren_n = 1'b0;
    rstep();
    ren_n = 1'b1;
    repeat (40) @(posedge clk);
    #1;
    `CHK("room after read", 1'b0, irdy_n)
  endtask

  // strobe low with select from the start: the first word is skipped
  task early_strobe;
    master_reset(1'b1, 1'b1);
    rcs_n = 1'b0;
    ren_n = 1'b0;
    far.push(wd(20));
    far.push(wd(21));
    drain();
    ren_n = 1'b1;
    rstep();
    `CHK("second shown", wd(21), dout)
  endtask

  // offsets come back in turn, with the strobe high for a cycle between accesses
  task offset_read;
    master_reset(1'b1, 1'b0);
    ofs_acc = 1'b1;
    rcs_n = 1'b0;
    ren_n = 1'b0;
    rstep();
    `CHK("ae offset", 36'(ae_ofs), dout)
    ren_n = 1'b1;
    rstep();
    ren_n = 1'b0;
    rstep();
    `CHK("af offset", 36'h000000008, dout)
    ren_n = 1'b1;
    rcs_n = 1'b1;
    ofs_acc = 1'b0;
  endtask

  // ten words give more than the least distance, so the mark takes hold
  task mark_retransmit;
    int i;
    master_reset(1'b1, 1'b0);
    for (i = 0; i < 10; i++) far.push(wd(30 + i));
    drain();
    mark_n = 1'b0;
    rcs_n = 1'b0;
    ren_n = 1'b0;
    for (i = 0; i < 2; i++)
    begin
      rstep();
      `CHK("marked read", wd(30 + i), dout)
    end
    ren_n = 1'b1;
    rt_n = 1'b0;
    rstep();
    `CHK("setup empty", 1'b0, empty_n)
    rt_n = 1'b1;
    rstep();
    `CHK("setup done", 1'b1, empty_n)
    ren_n = 1'b0;
    rstep();
    `CHK("retransmitted", wd(30), dout)
    ren_n = 1'b1;
    rcs_n = 1'b1;
    mark_n = 1'b1;
  endtask

  initial
  begin
    rst_n = 1'b0;
    mrs_n = 1'b1;
    fts = 1'b1;
    fall_through_mode = 1'b0;
    rcs_n = 1'b1;
    ren_n = 1'b1;
    oe_n = 1'b0;
    ae_ofs = 11'h002;
    rt_n = 1'b1;
    mark_n = 1'b1;
    ofs_acc = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (11) @(posedge clk);
    #1;
    `CHK("reset flags", 9'h067, {oe, empty_n, ordy_n, full_n, irdy_n, ae_n, af_n, hf_n, echo_n})
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    std_flow(1'b1);
    std_flow(1'b0);
    fall_through_mode_flow();
    early_strobe();
    offset_read();
    mark_retransmit();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
